// ==== hw/dphy_rx_lane.sv ====
`timescale 1ns/1ps
module dphy_rx_lane (
    input  wire logic       mclk,
    input  wire logic       arst_n,
    input  wire logic       clk_lp_p,
    input  wire logic       clk_lp_n,
    input  wire logic       dat_lp_p,
    input  wire logic       dat_lp_n,
    input  wire logic       hs_clk_in,
    input  wire logic       hs_dat_in,
    input  wire logic       force_reinit,
    output logic            clock_lane_hs_clock_active,
    output logic            clock_lane_ulp_state_n,
    output logic            hs_byte_clk,
    output logic [7:0]      hs_data,
    output logic            hs_valid,
    output logic            hs_active,
    output logic            hs_sync_seen,
    output logic            esc_clk,
    output logic            esc_lpdt_mode,
    output logic            esc_ulps,
    output logic [3:0]      esc_trigger,
    output logic [7:0]      esc_data,
    output logic            esc_valid
);
    lane_pins_if lane ();

    pin_filter u_filter (
        .mclk   (mclk),
        .arst_n (arst_n),
        .pins   ({force_reinit, hs_dat_in, hs_clk_in, dat_lp_p, dat_lp_n, clk_lp_p, clk_lp_n}),
        .lane   (lane)
    );

    // Trigger bit for a command, zero when not a trigger
    function automatic logic [3:0] trig_of(input logic [7:0] cmd);
        case (cmd)
            dphy_rx_pkg::CMD_TRIG_RESET: trig_of = dphy_rx_pkg::TRIG_RESET;
            dphy_rx_pkg::CMD_TRIG_UNK3:  trig_of = dphy_rx_pkg::TRIG_UNK3;
            dphy_rx_pkg::CMD_TRIG_UNK4:  trig_of = dphy_rx_pkg::TRIG_UNK4;
            dphy_rx_pkg::CMD_TRIG_UNK5:  trig_of = dphy_rx_pkg::TRIG_UNK5;
            default:                     trig_of = 4'h0;
        endcase
    endfunction

    // ---------------- Clock lane ----------------
    dphy_rx_pkg::clk_state_t cl_state_r;
    dphy_rx_pkg::clk_state_t cl_state_nxt;
    logic                    hs_clk_prev_r;
    logic [7:0]              act_cnt_r;
    logic                    cl_active_r;
    logic                    cl_ulp_n_r;
    logic                    hs_edge;

    assign hs_edge = lane.hs_clk ^ hs_clk_prev_r;

    // Stop from any state; LP-01 then LP-00 is HS, LP-10 then LP-00 is ULP
    always_comb
    begin
        cl_state_nxt = cl_state_r;
        if (lane.clk_lp == dphy_rx_pkg::LP_11)
            cl_state_nxt = dphy_rx_pkg::CL_STOP;
        else
        begin
            case (cl_state_r)
                dphy_rx_pkg::CL_STOP:
                    if (lane.clk_lp == dphy_rx_pkg::LP_01)
                        cl_state_nxt = dphy_rx_pkg::CL_HS_RQ;
                    else if (lane.clk_lp == dphy_rx_pkg::LP_10)
                        cl_state_nxt = dphy_rx_pkg::CL_ULP_RQ;
                dphy_rx_pkg::CL_HS_RQ:
                    if (lane.clk_lp == dphy_rx_pkg::LP_00)
                        cl_state_nxt = dphy_rx_pkg::CL_HS;
                dphy_rx_pkg::CL_ULP_RQ:
                    if (lane.clk_lp == dphy_rx_pkg::LP_00)
                        cl_state_nxt = dphy_rx_pkg::CL_ULP;
                dphy_rx_pkg::CL_HS, dphy_rx_pkg::CL_ULP:
                    cl_state_nxt = cl_state_r;
                default:
                    cl_state_nxt = dphy_rx_pkg::CL_STOP;
            endcase
        end
    end

    // Activity window restarts on every DDR edge
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            cl_state_r    <= dphy_rx_pkg::CL_STOP;
            hs_clk_prev_r <= 1'b0;
            act_cnt_r     <= 8'h00;
            cl_active_r   <= 1'b0;
            cl_ulp_n_r    <= 1'b1;
        end
        else
        begin
            cl_state_r    <= cl_state_nxt;
            hs_clk_prev_r <= lane.hs_clk;
            if (cl_state_nxt != dphy_rx_pkg::CL_HS)
                act_cnt_r <= 8'h00;
            else if (hs_edge)
                act_cnt_r <= dphy_rx_pkg::ACT_WINDOW;
            else if (act_cnt_r != 8'h00)
                act_cnt_r <= act_cnt_r - 8'h01;
            cl_active_r <= (cl_state_nxt == dphy_rx_pkg::CL_HS)
                           && (hs_edge || act_cnt_r > 8'h01);
            cl_ulp_n_r  <= (cl_state_nxt != dphy_rx_pkg::CL_ULP);
        end
    end

    // ---------------- Data lane ----------------
    dphy_rx_pkg::lane_state_t st_r;
    dphy_rx_pkg::lane_state_t st_nxt;
    logic [1:0] lp_prev_r;
    logic       lp_changed;
    logic       esc_bit_evt;
    logic       esc_bit;
    logic [7:0] esc_sh_r;
    logic [7:0] esc_sh_nxt;
    logic [2:0] esc_cnt_r;
    logic       cmd_done;
    logic [7:0] hs_sh_r;
    logic [7:0] hs_sh_nxt;
    logic [2:0] hs_cnt_r;
    logic       hs_bit_evt;
    logic       hs_sync_hit;
    logic       hs_byte_done;
    logic       stop_seen;

    assign stop_seen   = (lane.dat_lp == dphy_rx_pkg::LP_11) || lane.force_reinit;
    assign lp_changed  = lane.dat_lp != lp_prev_r;
    // Spaced-one-hot: mark after a space carries one bit
    assign esc_bit_evt = lp_changed && (lp_prev_r == dphy_rx_pkg::LP_00)
                         && (lane.dat_lp == dphy_rx_pkg::LP_10
                             || lane.dat_lp == dphy_rx_pkg::LP_01)
                         && (st_r == dphy_rx_pkg::ST_ESC_CMD || st_r == dphy_rx_pkg::ST_ESC_RUN);
    assign esc_bit     = (lane.dat_lp == dphy_rx_pkg::LP_10);
    assign esc_sh_nxt  = (st_r == dphy_rx_pkg::ST_ESC_CMD) ? {esc_sh_r[6:0], esc_bit}
                                                           : {esc_bit, esc_sh_r[7:1]};
    assign cmd_done    = esc_bit_evt && (st_r == dphy_rx_pkg::ST_ESC_CMD) && (esc_cnt_r == 3'h7);
    assign hs_bit_evt  = (st_r == dphy_rx_pkg::ST_HS) && hs_edge;
    assign hs_sh_nxt   = {lane.hs_dat, hs_sh_r[7:1]};
    assign hs_sync_hit = hs_bit_evt && !hs_active && (hs_sh_nxt == dphy_rx_pkg::HS_SYNC_BYTE);
    assign hs_byte_done = hs_bit_evt && hs_active && (hs_cnt_r == 3'h7);

    // Lane mode sequencing; Stop or force returns to idle from anywhere
    always_comb
    begin
        st_nxt = st_r;
        if (stop_seen)
            st_nxt = dphy_rx_pkg::ST_STOP;
        else if (lp_changed || cmd_done)
        begin
            case (st_r)
                dphy_rx_pkg::ST_STOP:
                    st_nxt = (lane.dat_lp == dphy_rx_pkg::LP_01) ? dphy_rx_pkg::ST_HS_RQ :
                             (lane.dat_lp == dphy_rx_pkg::LP_10) ? dphy_rx_pkg::ST_ESC_RQ :
                             dphy_rx_pkg::ST_WAIT;
                dphy_rx_pkg::ST_HS_RQ:
                    st_nxt = (lane.dat_lp == dphy_rx_pkg::LP_00) ? dphy_rx_pkg::ST_HS
                                                                 : dphy_rx_pkg::ST_WAIT;
                dphy_rx_pkg::ST_ESC_RQ:
                    st_nxt = (lane.dat_lp == dphy_rx_pkg::LP_00) ? dphy_rx_pkg::ST_ESC_BR
                                                                 : dphy_rx_pkg::ST_WAIT;
                dphy_rx_pkg::ST_ESC_BR:
                    st_nxt = (lane.dat_lp == dphy_rx_pkg::LP_01) ? dphy_rx_pkg::ST_ESC_AK
                                                                 : dphy_rx_pkg::ST_WAIT;
                dphy_rx_pkg::ST_ESC_AK:
                    st_nxt = (lane.dat_lp == dphy_rx_pkg::LP_00) ? dphy_rx_pkg::ST_ESC_CMD
                                                                 : dphy_rx_pkg::ST_WAIT;
                dphy_rx_pkg::ST_ESC_CMD:
                    if (cmd_done)
                        st_nxt = (esc_sh_nxt == dphy_rx_pkg::CMD_LPDT
                                  || esc_sh_nxt == dphy_rx_pkg::CMD_ULPS
                                  || trig_of(esc_sh_nxt) != 4'h0) ? dphy_rx_pkg::ST_ESC_RUN
                                                                  : dphy_rx_pkg::ST_WAIT;
                dphy_rx_pkg::ST_HS, dphy_rx_pkg::ST_ESC_RUN, dphy_rx_pkg::ST_WAIT:
                    st_nxt = st_r;
                default:
                    st_nxt = dphy_rx_pkg::ST_STOP;
            endcase
        end
    end

    // Data-lane state and line history
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            st_r      <= dphy_rx_pkg::ST_STOP;
            lp_prev_r <= dphy_rx_pkg::LP_11;
        end
        else
        begin
            st_r      <= st_nxt;
            lp_prev_r <= lane.dat_lp;
        end
    end

    // HS deserialiser: sync hunt, then bytes every eight DDR edges
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            hs_sh_r      <= 8'h00;
            hs_cnt_r     <= 3'h0;
            hs_active    <= 1'b0;
            hs_sync_seen <= 1'b0;
            hs_valid     <= 1'b0;
            hs_data      <= 8'h00;
            hs_byte_clk  <= 1'b0;
        end
        else if (st_nxt != dphy_rx_pkg::ST_HS)
        begin
            hs_sh_r      <= 8'h00;
            hs_cnt_r     <= 3'h0;
            hs_active    <= 1'b0;
            hs_sync_seen <= 1'b0;
            hs_valid     <= 1'b0;
            hs_byte_clk  <= 1'b0;
        end
        else
        begin
            if (hs_bit_evt)
            begin
                hs_sh_r  <= hs_sh_nxt;
                hs_cnt_r <= hs_active ? hs_cnt_r + 3'h1 : 3'h0;
            end
            if (hs_sync_hit)
            begin
                hs_active    <= 1'b1;
                hs_sync_seen <= 1'b1;
                hs_byte_clk  <= 1'b1;
            end
            else if (hs_byte_done)
            begin
                hs_sync_seen <= 1'b0;
                hs_data      <= hs_sh_nxt;
                hs_valid     <= 1'b1;
                hs_byte_clk  <= 1'b1;
            end
            else if (hs_bit_evt && hs_active && hs_cnt_r + 3'h1 == dphy_rx_pkg::BYTE_CLK_HALF)
                hs_byte_clk <= 1'b0;
        end
    end

    // Escape receiver: command decode, LP data bytes, sticky mode flags
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            esc_sh_r      <= 8'h00;
            esc_cnt_r     <= 3'h0;
            esc_clk       <= 1'b0;
            esc_lpdt_mode <= 1'b0;
            esc_ulps      <= 1'b0;
            esc_trigger   <= 4'h0;
            esc_data      <= 8'h00;
            esc_valid     <= 1'b0;
        end
        else if (stop_seen)
        begin
            esc_cnt_r     <= 3'h0;
            esc_clk       <= 1'b0;
            esc_lpdt_mode <= 1'b0;
            esc_ulps      <= 1'b0;
            esc_trigger   <= 4'h0;
            esc_valid     <= 1'b0;
        end
        else
        begin
            esc_clk   <= (st_r == dphy_rx_pkg::ST_ESC_CMD || st_r == dphy_rx_pkg::ST_ESC_RUN)
                         && (lane.dat_lp[1] ^ lane.dat_lp[0]);
            esc_valid <= 1'b0;
            if (esc_bit_evt)
            begin
                esc_sh_r  <= esc_sh_nxt;
                esc_cnt_r <= esc_cnt_r + 3'h1;
            end
            if (cmd_done)
            begin
                esc_lpdt_mode <= (esc_sh_nxt == dphy_rx_pkg::CMD_LPDT);
                esc_ulps      <= (esc_sh_nxt == dphy_rx_pkg::CMD_ULPS);
                esc_trigger   <= trig_of(esc_sh_nxt);
            end
            else if (esc_bit_evt && esc_lpdt_mode && esc_cnt_r == 3'h7)
            begin
                esc_data  <= esc_sh_nxt;
                esc_valid <= 1'b1;
            end
        end
    end

    assign clock_lane_hs_clock_active = cl_active_r;
    assign clock_lane_ulp_state_n     = cl_ulp_n_r;
endmodule // dphy_rx_lane

// ==== hw/dphy_rx_pkg.sv ====
package dphy_rx_pkg;
    // Line states as {p, n}
    localparam logic [1:0] LP_11 = 2'h3;
    localparam logic [1:0] LP_10 = 2'h2;
    localparam logic [1:0] LP_01 = 2'h1;
    localparam logic [1:0] LP_00 = 2'h0;
    // HS leader byte, bit 0 earliest
    localparam logic [7:0] HS_SYNC_BYTE = 8'hb8;
    // Escape entry commands, first received bit in bit 7
    localparam logic [7:0] CMD_LPDT = 8'he1;
    localparam logic [7:0] CMD_ULPS = 8'h1e;
    localparam logic [7:0] CMD_TRIG_RESET = 8'h62;
    localparam logic [7:0] CMD_TRIG_UNK3 = 8'h5d;
    localparam logic [7:0] CMD_TRIG_UNK4 = 8'h21;
    localparam logic [7:0] CMD_TRIG_UNK5 = 8'ha0;
    localparam logic [3:0] TRIG_RESET = 4'h1;
    localparam logic [3:0] TRIG_UNK3 = 4'h2;
    localparam logic [3:0] TRIG_UNK4 = 4'h4;
    localparam logic [3:0] TRIG_UNK5 = 4'h8;
    // Byte-clock half period in bits
    localparam logic [2:0] BYTE_CLK_HALF = 3'h4;
    // Clock-lane activity window
    localparam int CLK_MHZ = 200;
    localparam int ACT_WINDOW_NS = 100;
    localparam int ACT_WINDOW_CYC = (ACT_WINDOW_NS * CLK_MHZ) / 1000;
    localparam logic [7:0] ACT_WINDOW = 8'(ACT_WINDOW_CYC);
    // Synchroniser width: clk lp(2), dat lp(2), hs clk, hs dat, force
    localparam int PIN_W = 7;

    typedef enum logic [3:0] {
        ST_STOP    = 4'h0,
        ST_HS_RQ   = 4'h1,
        ST_HS      = 4'h3,
        ST_ESC_RQ  = 4'h2,
        ST_ESC_BR  = 4'h6,
        ST_ESC_AK  = 4'h7,
        ST_ESC_CMD = 4'h5,
        ST_ESC_RUN = 4'h4,
        ST_WAIT    = 4'hc
    } lane_state_t;

    typedef enum logic [2:0] {
        CL_STOP   = 3'h0,
        CL_HS_RQ  = 3'h1,
        CL_HS     = 3'h3,
        CL_ULP_RQ = 3'h2,
        CL_ULP    = 3'h6
    } clk_state_t;
endpackage

// ==== hw/lane_pins_if.sv ====
`timescale 1ns/1ps
// Filtered lane pins passed from the synchroniser to the receiver core
interface lane_pins_if;
    logic [1:0] clk_lp;
    logic [1:0] dat_lp;
    logic       hs_clk;
    logic       hs_dat;
    logic       force_reinit;
    modport src  (output clk_lp, dat_lp, hs_clk, hs_dat, force_reinit);
    modport sink (input clk_lp, dat_lp, hs_clk, hs_dat, force_reinit);
endinterface

// ==== hw/pin_filter.sv ====
`timescale 1ns/1ps
// Three-stage synchroniser, a change counts once stages two and three agree
module pin_filter (
    input  wire logic                         mclk,
    input  wire logic                         arst_n,
    input  wire logic [dphy_rx_pkg::PIN_W-1:0] pins,
    lane_pins_if.src                          lane
);
    logic [dphy_rx_pkg::PIN_W-1:0] s1_r;
    logic [dphy_rx_pkg::PIN_W-1:0] s2_r;
    logic [dphy_rx_pkg::PIN_W-1:0] s3_r;
    logic [dphy_rx_pkg::PIN_W-1:0] stable_r;
    logic [dphy_rx_pkg::PIN_W-1:0] stable_nxt;

    // Per-bit update where the last two stages agree
    assign stable_nxt = (s2_r & s3_r) | (stable_r & (s2_r ^ s3_r));

    // Idle lines rest at LP-11, force released
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            s1_r     <= 7'h0f;
            s2_r     <= 7'h0f;
            s3_r     <= 7'h0f;
            stable_r <= 7'h0f;
        end
        else
        begin
            s1_r     <= pins;
            s2_r     <= s1_r;
            s3_r     <= s2_r;
            stable_r <= stable_nxt;
        end
    end

    assign lane.clk_lp       = stable_r[1:0];
    assign lane.dat_lp       = stable_r[3:2];
    assign lane.hs_clk       = stable_r[4];
    assign lane.hs_dat       = stable_r[5];
    assign lane.force_reinit = stable_r[6];
endmodule // pin_filter

// ==== test/dphy_rx_lane_ppi_bench.sv ====
`timescale 1ns/1ps
module dphy_rx_lane_ppi_bench;
    logic       mclk, arst_n, force_reinit;
    logic       clk_lp_p, clk_lp_n, dat_lp_p, dat_lp_n, hs_clk_in, hs_dat_in;
    logic       clock_lane_hs_clock_active, clock_lane_ulp_state_n, hs_byte_clk;
    logic [7:0] hs_data, esc_data;
    logic       hs_valid, hs_active, hs_sync_seen, esc_clk, esc_lpdt_mode, esc_ulps;
    logic [3:0] esc_trigger;
    logic       esc_valid, first_r, bclk_prev;
    logic [8:0] exp_q[$];
    logic [7:0] bq[$];
    logic [31:0] seed;
    int         n_fail, n_compared;
    localparam logic [7:0] CMDS[7] = '{dphy_rx_pkg::CMD_LPDT, dphy_rx_pkg::CMD_ULPS,
        dphy_rx_pkg::CMD_TRIG_RESET, dphy_rx_pkg::CMD_TRIG_UNK3, dphy_rx_pkg::CMD_TRIG_UNK4,
        dphy_rx_pkg::CMD_TRIG_UNK5, 8'h00};
    localparam logic [5:0] FLAGS[7] = '{6'h20, 6'h10, {2'h0, dphy_rx_pkg::TRIG_RESET},
        {2'h0, dphy_rx_pkg::TRIG_UNK3}, {2'h0, dphy_rx_pkg::TRIG_UNK4},
        {2'h0, dphy_rx_pkg::TRIG_UNK5}, 6'h00};

    dphy_tx_model i_tx (.mclk, .clk_lp_p, .clk_lp_n, .dat_lp_p, .dat_lp_n, .hs_clk_in, .hs_dat_in);
    dphy_rx_lane i_dut (.mclk, .arst_n, .clk_lp_p, .clk_lp_n, .dat_lp_p, .dat_lp_n, .hs_clk_in,
        .hs_dat_in, .force_reinit, .clock_lane_hs_clock_active, .clock_lane_ulp_state_n,
        .hs_byte_clk, .hs_data, .hs_valid, .hs_active, .hs_sync_seen, .esc_clk, .esc_lpdt_mode,
        .esc_ulps, .esc_trigger, .esc_data, .esc_valid);

    // 200 MHz clock
    initial
    begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end
    task automatic chk(input logic [8:0] seen, input logic [8:0] want);
        n_compared++;
        if (seen !== want)
        begin
            n_fail++;
            $display("BAD %0t seen %h expected %h", $time, seen, want);
        end
    endtask
    function automatic logic [7:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[7:0];
    endfunction
    task automatic idle(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task automatic stop_test();
        $display("Compared %0d, mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // Take the oldest note off the queue at each delivered byte
    always @(negedge mclk)
    begin
        if (hs_byte_clk && !bclk_prev)
        begin
            chk(9'(hs_sync_seen), 9'(first_r));
            chk(9'(hs_valid), 9'(!first_r));
            chk(9'(clock_lane_hs_clock_active), 9'h001);
            if (!first_r) chk({1'b0, hs_data}, exp_q.pop_front());
            first_r = 1'b0;
        end
        if (!hs_active) first_r = 1'b1;
        if (esc_valid) chk({1'b1, esc_data}, exp_q.pop_front());
        bclk_prev = hs_byte_clk;
    end
    // Cut a hang short
    initial
    begin
        repeat (40000) @(posedge mclk);
        n_fail++;
        $display("BAD %0t watchdog expired", $time);
        stop_test();
    end
    // Main sequence
    initial
    begin
        {arst_n, force_reinit, n_fail, n_compared, bclk_prev} = '0;
        {first_r, seed} = {1'b1, 32'h31};
        idle(3);
        chk({6'h00, clock_lane_ulp_state_n, hs_active, hs_valid}, 9'h004);
        chk({3'h0, esc_lpdt_mode, esc_ulps, esc_trigger}, 9'h000);
        idle(1);
        arst_n = 1'b1;
        // Force held in Stop, released after the init time
        force_reinit = 1'b1;
        idle(40);
        force_reinit = 1'b0;
        idle(8);
        $display("Test reset and force done");
        // HS burst with a partial trailing byte
        for (int i = 0; i < 3; i++) bq.push_back(rnd());
        foreach (bq[i]) exp_q.push_back({1'b0, bq[i]});
        i_tx.hs_burst(bq, 5);
        idle(25);
        chk({5'h00, hs_active, hs_valid, hs_byte_clk, clock_lane_hs_clock_active}, 9'h0);
        chk(9'(exp_q.size()), 9'h0);
        $display("Test hs burst done");
        // Clock lane ultra-low power
        i_tx.clk_lp(dphy_rx_pkg::LP_10);
        i_tx.clk_lp(dphy_rx_pkg::LP_00);
        idle(4);
        chk(9'(clock_lane_ulp_state_n), 9'h000);
        i_tx.clk_lp(dphy_rx_pkg::LP_11);
        idle(6);
        chk(9'(clock_lane_ulp_state_n), 9'h001);
        $display("Test clock ulp done");
        // Every escape command, an unknown one last
        for (int c = 0; c < 7; c++)
        begin
            bq.delete();
            if (c == 0) for (int i = 0; i < 2; i++) bq.push_back(rnd());
            foreach (bq[i]) exp_q.push_back({1'b1, bq[i]});
            i_tx.esc_seq(CMDS[c], bq);
            idle(4);
            chk(9'({esc_lpdt_mode, esc_ulps, esc_trigger}), 9'(FLAGS[c]));
            i_tx.dat_lp(dphy_rx_pkg::LP_11);
            idle(4);
            chk(9'({esc_lpdt_mode, esc_ulps, esc_trigger}), 9'h0);
        end
        chk(9'(exp_q.size()), 9'h0);
        $display("Test escape done");
        stop_test();
    end
endmodule // dphy_rx_lane_ppi_bench

// ==== test/dphy_rx_lane_sva.sv ====
`timescale 1ns/1ps
// Port-level checks on the receive lane outputs
module dphy_rx_lane_sva (
    input wire logic       mclk,
    input wire logic       arst_n,
    input wire logic       clock_lane_hs_clock_active,
    input wire logic       clock_lane_ulp_state_n,
    input wire logic       hs_byte_clk,
    input wire logic [7:0] hs_data,
    input wire logic       hs_valid,
    input wire logic       hs_active,
    input wire logic       hs_sync_seen,
    input wire logic       esc_clk,
    input wire logic       esc_lpdt_mode,
    input wire logic       esc_ulps,
    input wire logic [3:0] esc_trigger,
    input wire logic       esc_valid
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!arst_n);

    // High-speed burst framing
    AST_HS_VALID_IN_BURST: assert property (hs_valid |-> hs_active)
        else $error("hs valid outside burst");
    AST_BYTE_CLK_ONLY_HS: assert property (hs_byte_clk |-> hs_active)
        else $error("byte clock outside burst");
    AST_SYNC_AT_START: assert property (
        $rose(hs_active) |-> hs_sync_seen && hs_byte_clk && !hs_valid)
        else $error("sync missing at burst start");
    AST_SYNC_ONLY_START: assert property (hs_sync_seen |-> hs_active && !hs_valid)
        else $error("sync outside burst start");
    AST_SYNC_ENDS_WITH_BYTE: assert property (
        $fell(hs_sync_seen) && hs_active |-> hs_valid && $rose(hs_byte_clk))
        else $error("sync longer than one byte clock");
    AST_DATA_ON_BYTE_CLK: assert property (
        $changed(hs_data) && hs_active |-> $rose(hs_byte_clk))
        else $error("hs data changed off byte clock");
    // Escape and lane state flags
    AST_ESC_VALID_ON_CLK: assert property (esc_valid |-> $rose(esc_clk) && esc_lpdt_mode)
        else $error("escape byte without clock or mode");
    AST_ESC_VALID_PULSE: assert property (esc_valid |=> !esc_valid)
        else $error("escape valid longer than a pulse");
    AST_TRIG_STICKY: assert property (
        (esc_trigger != 4'h0) |-> $onehot(esc_trigger)
        ##1 (esc_trigger == $past(esc_trigger) || esc_trigger == 4'h0))
        else $error("trigger not one-hot or changed");
    AST_ULPS_EXCL: assert property (esc_ulps |-> !esc_lpdt_mode && esc_trigger == 4'h0)
        else $error("ulp flag with other escape mode");
    AST_CLK_ACTIVE_NOT_ULP: assert property (
        clock_lane_hs_clock_active |-> clock_lane_ulp_state_n)
        else $error("clock active while in ulp");

    // Main scenarios reached
    COV_HS_BYTE: cover property ($rose(hs_valid));
    COV_ESC_BYTE: cover property (esc_valid);
    COV_CLK_ULP: cover property ($fell(clock_lane_ulp_state_n));
endmodule // dphy_rx_lane_sva

bind dphy_rx_lane dphy_rx_lane_sva i_sva (.mclk, .arst_n, .clock_lane_hs_clock_active,
    .clock_lane_ulp_state_n, .hs_byte_clk, .hs_data, .hs_valid, .hs_active, .hs_sync_seen,
    .esc_clk, .esc_lpdt_mode, .esc_ulps, .esc_trigger, .esc_valid);

// ==== test/dphy_tx_model.sv ====
`timescale 1ns/1ps
// Behavioural transmitter on the clock and data lanes
module dphy_tx_model (
    input  wire logic mclk,
    output logic      clk_lp_p,
    output logic      clk_lp_n,
    output logic      dat_lp_p,
    output logic      dat_lp_n,
    output logic      hs_clk_in,
    output logic      hs_dat_in
);
    localparam int HOLD = 6;
    // Lines idle in Stop, HS clock still
    initial
    begin
        {clk_lp_p, clk_lp_n, dat_lp_p, dat_lp_n} = 4'hf;
        hs_clk_in = 1'b0;
        hs_dat_in = 1'b0;
    end
    // Changes land a small delay after an edge
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task automatic clk_lp(input logic [1:0] v);
        {clk_lp_p, clk_lp_n} = v;
        tick(HOLD);
    endtask
    task automatic dat_lp(input logic [1:0] v);
        {dat_lp_p, dat_lp_n} = v;
        tick(HOLD);
    endtask
    // One HS bit, data settled around the clock change
    task automatic hs_bit(input logic b);
        hs_dat_in = b;
        tick(3);
        hs_clk_in = ~hs_clk_in;
        tick(3);
    endtask
    // Whole burst with leader, payload and trailing bits
    task automatic hs_burst(input logic [7:0] b[$], input int extra);
        clk_lp(dphy_rx_pkg::LP_01);
        clk_lp(dphy_rx_pkg::LP_00);
        dat_lp(dphy_rx_pkg::LP_01);
        dat_lp(dphy_rx_pkg::LP_00);
        for (int i = 0; i < 8; i++) hs_bit(dphy_rx_pkg::HS_SYNC_BYTE[i]);
        foreach (b[k]) for (int i = 0; i < 8; i++) hs_bit(b[k][i]);
        for (int i = 0; i < extra; i++) hs_bit(i[0]);
        hs_dat_in = ~hs_dat_in; // Released line shows no stale bit
        dat_lp(dphy_rx_pkg::LP_11);
        clk_lp(dphy_rx_pkg::LP_11);
    endtask
    // Spaced one-hot bit: mark then space
    task automatic esc_bit(input logic b);
        dat_lp(b ? dphy_rx_pkg::LP_10 : dphy_rx_pkg::LP_01);
        dat_lp(dphy_rx_pkg::LP_00);
    endtask
    // Escape entry, command first bit in MSB, then data LSB first
    task automatic esc_seq(input logic [7:0] cmd, input logic [7:0] b[$]);
        dat_lp(dphy_rx_pkg::LP_10);
        dat_lp(dphy_rx_pkg::LP_00);
        dat_lp(dphy_rx_pkg::LP_01);
        dat_lp(dphy_rx_pkg::LP_00);
        for (int i = 7; i >= 0; i--) esc_bit(cmd[i]);
        foreach (b[k]) for (int i = 0; i < 8; i++) esc_bit(b[k][i]);
    endtask
endmodule // dphy_tx_model
